// >>> rtl/sdlp_defs.vh
`ifndef SDLP_DEFS_VH
`define SDLP_DEFS_VH
// register byte offsets
`define SDLP_OFS_TIMING2 12'h000
`define SDLP_OFS_LOWPWR 12'h004
`define SDLP_OFS_MEMTYPE 12'h008
`define SDLP_OFS_DLLSTAT 12'h00C
`define SDLP_OFS_SCHED 12'h010
`define SDLP_OFS_WPROT 12'h014
`define SDLP_OFS_DELAY0 12'h020
`define SDLP_NUM_DELAY 3'h5
// low-power field positions
`define SDLP_LP_CMD_LSB 0
`define SDLP_LP_CLKFR_BIT 2
`define SDLP_LP_PARTIAL_ARRAY_REFRESH_LSB 4
`define SDLP_LP_TCR_LSB 8
`define SDLP_LP_DS_LSB 10
`define SDLP_LP_TOUT_LSB 12
`define SDLP_LP_POWERDOWN_EXIT_SPEED_BIT 16
`define SDLP_LP_RESET 32'h00010000
`define SDLP_LP_WMASK 32'h00013F77
// memory type
`define SDLP_MT_SDR 3'h0
`define SDLP_MT_LPSDR 3'h1
`define SDLP_MT_LPDDR 3'h3
`define SDLP_MT_DDR2 3'h6
`define SDLP_MD_RESET 32'h00000010
`define SDLP_MD_WMASK 32'h00000017
`define SDLP_HS_WMASK 32'h00000006
`define SDLP_T2_WMASK 32'h0000F000
`define SDLP_T2_READ_TO_PRECHARGE_DELAY_LSB 12
// low-power commands
`define SDLP_CMD_NONE 2'h0
`define SDLP_CMD_SREF 2'h1
`define SDLP_CMD_PDOWN 2'h2
`define SDLP_CMD_DPD 2'h3
// idle timeouts in cycles
`define SDLP_TOUT_64 8'h40
`define SDLP_TOUT_128 8'h80
`endif

// >>> rtl/sdlp_dll.v
`timescale 1ns/1ps
// master delay counter: tracks phase, saturates at max and forces lock
module sdlp_dll (
  input wire clk_sys_in, // controller clock
  input wire rst_in, // async reset
  input wire phase_late_in, // line too short, count up
  input wire phase_early_in, // line too long, count down
  output reg [7:0] value_out, // master delay value
  output reg up_out, // counter incrementing
  output reg down_out, // counter decrementing
  output reg overflow_out, // saturated at maximum
  output reg lock_out // master locked
);
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      value_out <= 8'h00;
      up_out <= 1'b0;
      down_out <= 1'b0;
      overflow_out <= 1'b0;
      lock_out <= 1'b0;
    end else begin
      up_out <= 1'b0;
      down_out <= 1'b0;
      if (overflow_out) begin
        lock_out <= 1'b1; // stays locked: clock too slow for the line
      end else if (phase_late_in && !phase_early_in) begin
        if (value_out == 8'hFF) begin
          overflow_out <= 1'b1;
          lock_out <= 1'b1;
        end else begin
          value_out <= value_out + 8'h01;
          up_out <= 1'b1;
          lock_out <= 1'b0;
        end
      end else if (phase_early_in && !phase_late_in) begin
        if (value_out != 8'h00) begin
          value_out <= value_out - 8'h01;
          down_out <= 1'b1;
        end
        lock_out <= 1'b0;
      end else begin
        lock_out <= 1'b1;
      end
    end
  end
endmodule

// >>> rtl/sdlp_sync2.v
`timescale 1ns/1ps
// two-flop synchroniser for a level from outside the clock domain
module sdlp_sync2 (
  input wire clk_sys_in, // controller clock
  input wire rst_in, // async reset
  input wire d_in, // asynchronous level
  output reg q_out // synchronised level
);
  reg meta;
  // meta feeds only the second flop
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      meta <= 1'b0;
      q_out <= 1'b0;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule

// >>> rtl/sdlp_top.v
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
`include "sdlp_defs.vh"
module sdlp_top (
  input wire clk_sys_in, // controller clock, 200 MHz
  input wire rst_in, // async reset, active high
  input wire psel_in, // apb select
  input wire penable_in, // apb enable
  input wire pwrite_in, // apb direction
  input wire [11:0] paddr_in, // apb byte address
  input wire [31:0] pwdata_in, // apb write data
  output wire [31:0] prdata_out, // apb read data
  output wire pready_out, // apb ready
  output wire pslverr_out, // apb error, unmapped address
  input wire access_req_in, // sequencer has an access pending
  input wire access_busy_in, // transfer in progress
  input wire init_done_in, // initialisation sequence done
  input wire bus_shared_in, // pin: external bus shared, async
  input wire phase_late_in, // dll phase detector: count up
  input wire phase_early_in, // dll phase detector: count down
  output reg [1:0] lp_cmd_out, // current low-power command state
  output reg cke_out, // memory clock enable
  output reg mem_clk_en_out, // memory clock running
  output reg ext_mode_wr_out, // pulse: write extended mode register
  output reg load_mode_wr_out, // pulse: write load mode register
  output reg [31:0] lp_cfg_out, // low-power configuration fields
  output reg [2:0] memory_type_out, // attached memory type
  output reg bus_width_select_out, // 1 = 16-bit bus
  output reg optimisation_disable_out, // scheduling optimisation off
  output reg early_read_disable_out, // anticipated reads off
  output reg [3:0] read_to_precharge_delay_out, // read to precharge
  output reg [7:0] master_delay_value_out, // strobe delay line setting
  output reg [159:0] line_element_count_out // all delay fields
);
  localparam ST_ACTIVE = 3'h0;
  localparam ST_IDLE = 3'h1;
  localparam ST_MODEWR = 3'h2;
  localparam ST_LOWPWR = 3'h3;
  localparam ST_EXIT = 3'h4;

  reg [31:0] low_power_control;
  reg [31:0] memory_type_select;
  reg [31:0] scheduling_options;
  reg [31:0] timing2;
  reg [31:0] io_delay_config [0:4];
  reg write_protect_enable;
  reg emr_dirty;
  reg mr_dirty;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [7:0] idle_cnt;
  reg [31:0] rdata;
  reg [31:0] rdata_q;
  reg hit;
  wire shared_sync;
  wire [7:0] dll_val;
  wire dll_up;
  wire dll_down;
  wire dll_ovf;
  wire dll_lock;
  integer i;

  wire wr_cyc = psel_in && penable_in && pwrite_in;
  wire [1:0] cmd = low_power_control[1:0];
  wire [1:0] tout = low_power_control[13:12];
  wire lp_mem = (memory_type_select[2:0] == `SDLP_MT_LPSDR) ||
    (memory_type_select[2:0] == `SDLP_MT_LPDDR);
  wire busy = access_req_in || access_busy_in;

  // takes write data in bits that software may write and keeps the old value of the rest
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [31:0] msk;
    begin
      merge = (old & ~msk) | (nw & msk);
    end
  endfunction

  // low-power word as a write would leave it; reserved bits never move,
  // so a stray one in write data cannot mark the mode registers stale
  wire [31:0] lp_new = merge(low_power_control, pwdata_in, `SDLP_LP_WMASK);

  // idle cycles needed before entry; 11 is reserved, treated as immediate
  function [7:0] tout_cycles;
    input [1:0] t;
    begin
      case (t)
        2'h1: tout_cycles = `SDLP_TOUT_64;
        2'h2: tout_cycles = `SDLP_TOUT_128;
        default: tout_cycles = 8'h00;
      endcase
    end
  endfunction

  // slot of a delay register, or 3'h7 when the address is none of them
  function [2:0] delay_slot;
    input [11:0] a;
    reg [11:0] d;
    begin
      d = a - `SDLP_OFS_DELAY0;
      if (d[1:0] == 2'h0 && d[11:2] < {7'h0, `SDLP_NUM_DELAY}) begin
        delay_slot = d[4:2];
      end else begin
        delay_slot = 3'h7;
      end
    end
  endfunction

  // bus-sharing pin comes from outside the domain
  sdlp_sync2 u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .d_in(bus_shared_in),
    .q_out(shared_sync)
  );

  sdlp_dll u_dll (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .phase_late_in(phase_late_in),
    .phase_early_in(phase_early_in),
    .value_out(dll_val),
    .up_out(dll_up),
    .down_out(dll_down),
    .overflow_out(dll_ovf),
    .lock_out(dll_lock)
  );

  // apb always answers in the access cycle, no wait states
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !hit;

  // register writes; protected registers ignore writes while protected
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      low_power_control <= `SDLP_LP_RESET;
      memory_type_select <= `SDLP_MD_RESET;
      scheduling_options <= 32'h00000000;
      timing2 <= 32'h00000000;
      write_protect_enable <= 1'b0;
      for (i = 0; i < 5; i = i + 1) begin
        io_delay_config[i] <= 32'h00000000;
      end
    end else if (wr_cyc) begin
      case (paddr_in)
        `SDLP_OFS_LOWPWR: low_power_control <=
          merge(low_power_control, pwdata_in, `SDLP_LP_WMASK);
        `SDLP_OFS_MEMTYPE: begin
          if (!write_protect_enable) begin
            memory_type_select <=
              merge(memory_type_select, pwdata_in, `SDLP_MD_WMASK);
          end
        end
        `SDLP_OFS_SCHED: begin
          if (!write_protect_enable) begin
            scheduling_options <=
              merge(scheduling_options, pwdata_in, `SDLP_HS_WMASK);
          end
        end
        `SDLP_OFS_TIMING2: begin
          if (!write_protect_enable) begin
            timing2 <= merge(timing2, pwdata_in, `SDLP_T2_WMASK);
          end
        end
        `SDLP_OFS_WPROT: write_protect_enable <= pwdata_in[0];
        default: begin
          if (delay_slot(paddr_in) != 3'h7) begin
            io_delay_config[delay_slot(paddr_in)] <= pwdata_in;
          end
        end
      endcase
    end
  end

  // dirty flags: a write that changes a field wins over the clear
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      emr_dirty <= 1'b0;
      mr_dirty <= 1'b0;
    end else begin
      if (wr_cyc && paddr_in == `SDLP_OFS_LOWPWR && init_done_in &&
          lp_new[11:4] != low_power_control[11:4]) begin
        emr_dirty <= 1'b1;
      end else if (state == ST_MODEWR) begin
        emr_dirty <= 1'b0;
      end
      if (wr_cyc && paddr_in == `SDLP_OFS_LOWPWR && init_done_in &&
          lp_new[`SDLP_LP_POWERDOWN_EXIT_SPEED_BIT] !=
          low_power_control[`SDLP_LP_POWERDOWN_EXIT_SPEED_BIT]) begin
        mr_dirty <= 1'b1;
      end else if (state == ST_MODEWR) begin
        mr_dirty <= 1'b0;
      end
    end
  end

  // read mux
  always @* begin
    rdata = 32'h00000000;
    hit = 1'b1;
    case (paddr_in)
      `SDLP_OFS_LOWPWR: rdata = low_power_control;
      `SDLP_OFS_MEMTYPE: rdata = memory_type_select;
      `SDLP_OFS_SCHED: rdata = scheduling_options;
      `SDLP_OFS_TIMING2: rdata = timing2;
      `SDLP_OFS_WPROT: rdata = {31'h0, write_protect_enable};
      `SDLP_OFS_DLLSTAT:
        rdata = {16'h0, dll_val, 5'h0, dll_ovf, dll_down, dll_up};
      default: begin
        if (delay_slot(paddr_in) != 3'h7) begin
          rdata = io_delay_config[delay_slot(paddr_in)];
        end else begin
          hit = 1'b0;
        end
      end
    endcase
  end

  // read word captured in the setup cycle and shown through the access
  // cycle: a flopped data output still meets the zero-wait answer
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= 32'h00000000;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      rdata_q <= rdata;
    end else begin
      rdata_q <= 32'h00000000;
    end
  end
  assign prdata_out = rdata_q;

  // low-power sequencer next state
  always @* begin
    next_state = state;
    case (state)
      ST_ACTIVE: begin
        if (!busy && cmd != `SDLP_CMD_NONE) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (busy || cmd == `SDLP_CMD_NONE) begin
          next_state = ST_ACTIVE;
        end else if (idle_cnt >= tout_cycles(tout)) begin
          if (cmd == `SDLP_CMD_DPD && !lp_mem) begin
            next_state = ST_IDLE;
          end else if (cmd == `SDLP_CMD_SREF && !shared_sync &&
              (emr_dirty || mr_dirty)) begin
            next_state = ST_MODEWR;
          end else begin
            next_state = ST_LOWPWR;
          end
        end
      end
      ST_MODEWR: next_state = ST_LOWPWR;
      ST_LOWPWR: begin
        if (busy && lp_cmd_out != `SDLP_CMD_DPD) begin
          next_state = ST_EXIT;
        end else if (cmd == `SDLP_CMD_NONE) begin
          next_state = ST_EXIT;
        end
      end
      ST_EXIT: next_state = ST_ACTIVE;
      default: next_state = ST_ACTIVE;
    endcase
  end

  // sequencer state, idle counter and memory-facing controls
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state <= ST_ACTIVE;
      idle_cnt <= 8'h00;
      lp_cmd_out <= `SDLP_CMD_NONE;
      cke_out <= 1'b1;
      mem_clk_en_out <= 1'b1;
      ext_mode_wr_out <= 1'b0;
      load_mode_wr_out <= 1'b0;
    end else begin
      state <= next_state;
      ext_mode_wr_out <= 1'b0;
      load_mode_wr_out <= 1'b0;
      if (state == ST_IDLE && next_state == ST_IDLE && idle_cnt != 8'hFF) begin
        idle_cnt <= idle_cnt + 8'h01;
      end else begin
        idle_cnt <= 8'h00;
      end
      if (next_state == ST_MODEWR) begin
        ext_mode_wr_out <= emr_dirty;
        load_mode_wr_out <= mr_dirty;
      end
      if (next_state == ST_LOWPWR && state != ST_LOWPWR) begin
        lp_cmd_out <= cmd;
        cke_out <= 1'b0;
        // self refresh always stops clock; others only when frozen
        mem_clk_en_out <= !(cmd == `SDLP_CMD_SREF ||
          low_power_control[`SDLP_LP_CLKFR_BIT]);
      end else if (next_state == ST_EXIT) begin
        lp_cmd_out <= `SDLP_CMD_NONE;
        cke_out <= 1'b1;
        mem_clk_en_out <= 1'b1;
      end
    end
  end

  // configuration fields registered out to the command sequencer
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      lp_cfg_out <= `SDLP_LP_RESET;
      memory_type_out <= `SDLP_MT_SDR;
      bus_width_select_out <= 1'b1;
      optimisation_disable_out <= 1'b0;
      early_read_disable_out <= 1'b0;
      read_to_precharge_delay_out <= 4'h0;
      master_delay_value_out <= 8'h00;
      line_element_count_out <= 160'h0;
    end else begin
      lp_cfg_out <= low_power_control;
      memory_type_out <= memory_type_select[2:0];
      bus_width_select_out <= memory_type_select[4];
      optimisation_disable_out <= scheduling_options[1];
      early_read_disable_out <= scheduling_options[2];
      read_to_precharge_delay_out <= timing2[15:12];
      if (dll_lock) begin
        master_delay_value_out <= dll_val;
      end
      for (i = 0; i < 5; i = i + 1) begin
        line_element_count_out[i*32 +: 32] <= io_delay_config[i];
      end
    end
  end
endmodule

// >>> tb/sdlp_mem_model.sv
`timescale 1ns/1ps
// far-side memory: counts mode register writes and closes the strobe
// delay loop; the loop mirrors one step per detector cycle, so it only
// aims the counter roughly, which is all the status checks need
module sdlp_mem_model (
  input wire clk_in, // controller clock
  input wire rst_in, // async reset
  input wire cke_in, // clock enable from controller
  input wire ext_wr_in, // extended mode register write
  input wire load_wr_in, // load mode register write
  input wire [8:0] target_in, // delay that centres the strobe
  output wire late_out, // strobe early, more delay wanted
  output wire early_out, // strobe late, less delay wanted
  output integer ext_cnt_out, // extended mode writes seen
  output integer load_cnt_out, // load mode writes seen
  output integer bad_cnt_out // mode writes with cke low
);
  reg [8:0] mirror;
  // one direction at a time, none once centred
  assign late_out = mirror < target_in;
  assign early_out = mirror > target_in;
  // a mode write is counted whatever cke is; one with cke low also counts as bad
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mirror <= 9'h000;
      ext_cnt_out <= 0;
      load_cnt_out <= 0;
      bad_cnt_out <= 0;
    end else begin
      if (late_out)
        mirror <= mirror + 9'h001;
      else if (early_out)
        mirror <= mirror - 9'h001;
      if (ext_wr_in)
        ext_cnt_out <= ext_cnt_out + 1;
      if (load_wr_in)
        load_cnt_out <= load_cnt_out + 1;
      if ((ext_wr_in || load_wr_in) && !cke_in)
        bad_cnt_out <= bad_cnt_out + 1;
    end
  end
endmodule

// >>> tb/sdlp_top_chk.sv
`timescale 1ns/1ps
module sdlp_top_chk (
  input wire clk_sys_in, // controller clock
  input wire rst_in, // async reset
  input wire access_req_in, // access pending
  input wire access_busy_in, // transfer running
  input wire init_done_in, // initialisation done
  input wire bus_shared_in, // shared bus pin
  input wire [1:0] lp_cmd_out, // command in force
  input wire cke_out, // memory clock enable
  input wire mem_clk_en_out, // memory clock running
  input wire ext_mode_wr_out, // extended mode write
  input wire load_mode_wr_out, // load mode write
  input wire [31:0] lp_cfg_out, // low-power fields
  input wire [2:0] memory_type_out // memory type
);
  reg [7:0] idle_cnt;
  wire [7:0] tout;
  // idle cycles since the last access, saturating at the top
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in)
      idle_cnt <= 8'h00;
    else if (access_req_in || access_busy_in)
      idle_cnt <= 8'h00;
    else if (idle_cnt != 8'hFF)
      idle_cnt <= idle_cnt + 8'h01;
  end
  // reserved timeout code acts as immediate entry
  assign tout = (lp_cfg_out[13:12] == 2'h1) ? 8'h40 :
                (lp_cfg_out[13:12] == 2'h2) ? 8'h80 : 8'h00;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  lp_off_a: assert property (
    lp_cmd_out == 2'h0 && lp_cfg_out[1:0] == 2'h0 &&
    $past(lp_cfg_out[1:0]) == 2'h0 && cke_out
    |=> cke_out) else $error("cke dropped with low power off");
  entry_cmd_a: assert property (
    $fell(cke_out) |-> ##[0:1] lp_cmd_out != 2'h0)
    else $error("cke low without a command");
  sref_clock_a: assert property (
    !cke_out && !$past(cke_out) && lp_cmd_out == 2'h1 |-> !mem_clk_en_out)
    else $error("clock runs in self refresh");
  freeze_a: assert property (
    !cke_out && !$past(cke_out) && lp_cmd_out[1]
    |-> mem_clk_en_out == !lp_cfg_out[2]) else $error("freeze bit ignored");
  wake_a: assert property (
    !cke_out && lp_cmd_out != 2'h3 && access_busy_in |-> ##[1:4] cke_out)
    else $error("no exit on access");
  mode_order_a: assert property (
    $rose(ext_mode_wr_out || load_mode_wr_out)
    |-> (init_done_in && lp_cfg_out[1:0] == 2'h1) ##[1:2] !cke_out)
    else $error("mode write out of place");
  shared_a: assert property (
    bus_shared_in [*4] |-> !ext_mode_wr_out && !load_mode_wr_out)
    else $error("mode write on shared bus");
  deep_type_a: assert property (
    !cke_out && lp_cmd_out == 2'h3
    |-> memory_type_out == 3'h1 || memory_type_out == 3'h3)
    else $error("deep power-down on wrong type");
  idle_wait_a: assert property (
    $fell(cke_out) |-> idle_cnt >= tout && idle_cnt <= tout + 8'h08)
    else $error("low-power entry at wrong time");
endmodule
bind sdlp_top sdlp_top_chk u_sdlp_top_chk (.clk_sys_in, .rst_in,
  .access_req_in, .access_busy_in, .init_done_in, .bus_shared_in,
  .lp_cmd_out, .cke_out, .mem_clk_en_out, .ext_mode_wr_out,
  .load_mode_wr_out, .lp_cfg_out, .memory_type_out);

// >>> tb/sdlp_top_tb.sv
`timescale 1ns/1ps
module sdlp_top_tb;
  reg clk_sys_in, rst_in, psel_in, penable_in, pwrite_in;
  reg [11:0] paddr_in;
  reg [31:0] pwdata_in, v, seed;
  reg access_req_in, access_busy_in, init_done_in, bus_shared_in;
  reg [8:0] target;
  wire phase_late_in, phase_early_in, pready_out, pslverr_out, cke_out;
  wire [31:0] prdata_out, lp_cfg_out;
  wire mem_clk_en_out, ext_mode_wr_out, load_mode_wr_out;
  wire bus_width_select_out, optimisation_disable_out;
  wire early_read_disable_out;
  wire [1:0] lp_cmd_out;
  wire [2:0] memory_type_out;
  wire [3:0] read_to_precharge_delay_out;
  wire [7:0] master_delay_value_out;
  wire [159:0] line_element_count_out;
  reg [31:0] exp_q[$];
  reg [31:0] msk_q[$];
  integer mismatches, tests_run, i, e0, l0, ec, lc, bad;
  sdlp_top u_sdlp_top (.clk_sys_in, .rst_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
    .pslverr_out, .access_req_in, .access_busy_in, .init_done_in,
    .bus_shared_in, .phase_late_in, .phase_early_in, .lp_cmd_out,
    .cke_out, .mem_clk_en_out, .ext_mode_wr_out, .load_mode_wr_out,
    .lp_cfg_out, .memory_type_out, .bus_width_select_out,
    .optimisation_disable_out, .early_read_disable_out,
    .read_to_precharge_delay_out, .master_delay_value_out,
    .line_element_count_out);
  sdlp_mem_model u_sdlp_mem_model (.clk_in(clk_sys_in), .rst_in(rst_in),
    .cke_in(cke_out), .ext_wr_in(ext_mode_wr_out),
    .load_wr_in(load_mode_wr_out), .target_in(target),
    .late_out(phase_late_in), .early_out(phase_early_in),
    .ext_cnt_out(ec), .load_cnt_out(lc), .bad_cnt_out(bad));
  // 200 MHz controller clock
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  task check(input [31:0] seen, input [31:0] want, input [63:0] nm);
    begin
      tests_run = tests_run + 1;
      if (seen !== want) begin
        mismatches = mismatches + 1;
        $display("unexpected %0s: expected %h, seen %h", nm, want, seen);
      end
    end
  endtask
  // one apb transfer; each call starts on a fresh edge
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clk_sys_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_sys_in);
      penable_in <= 1'b1;
      @(posedge clk_sys_in);
      while (pready_out !== 1'b1) @(posedge clk_sys_in);
      psel_in <= 1'b0;
      penable_in <= 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [31:0] e, input [31:0] m);
    begin
      exp_q.push_back(e);
      msk_q.push_back(m);
      apb(1'b0, a, 32'h00000000);
    end
  endtask
  task access(input integer n);
    begin
      @(posedge clk_sys_in);
      access_req_in <= 1'b1;
      access_busy_in <= 1'b1;
      @(posedge clk_sys_in);
      access_req_in <= 1'b0;
      repeat (n) @(posedge clk_sys_in);
      access_busy_in <= 1'b0;
    end
  endtask
  // busy covers the write so the idle count restarts after it
  task set_lp(input [31:0] d);
    begin
      @(posedge clk_sys_in);
      access_busy_in <= 1'b1;
      apb(1'b1, 12'h004, d);
      access(2);
    end
  endtask
  task wait_cke(input lvl);
    begin
      i = 0;
      while (cke_out !== lvl && i < 400) begin
        @(posedge clk_sys_in);
        i = i + 1;
      end
      @(negedge clk_sys_in);
    end
  endtask
  task end_sim;
    begin
      if (mismatches == 0 && tests_run > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // read answers are settled by the falling edge of the access phase
  always @(negedge clk_sys_in) begin
    if (psel_in && penable_in)
      check({31'h0, pslverr_out}, {31'h0, paddr_in == 12'h018}, "slverr");
    if (psel_in && penable_in && pready_out && !pwrite_in) begin
      check(prdata_out & msk_q[0], exp_q[0], "prdata");
      exp_q.pop_front();
      msk_q.pop_front();
    end
  end
  initial begin
    #100000;
    mismatches = mismatches + 1;
    end_sim;
  end
  initial begin
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = 0;
    {access_req_in, access_busy_in, init_done_in, bus_shared_in} = 0;
    mismatches = 0;
    tests_run = 0;
    seed = 32'h22D2;
    target = 9'h030;
    rst_in = 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rd(12'h00C, 32'h00000001, 32'h00000003);
    rd(12'h004, 32'h00010000, 32'hFFFFFFFF);
    rd(12'h008, 32'h00000010, 32'hFFFFFFFF);
    rd(12'h000, 32'h00000000, 32'hFFFFFFFF);
    v = $random(seed);
    apb(1'b1, 12'h000, v);
    rd(12'h000, v & 32'h0000F000, 32'hFFFFFFFF);
    check({28'h0, read_to_precharge_delay_out}, v[15:12], "read_to_precharge_delay");
    // memory types, ending on low-power sdr for the power tests
    for (i = 0; i < 4; i = i + 1) begin
      v[2:0] = (i == 0) ? 3'h0 : (i == 1) ? 3'h6 : (i == 2) ? 3'h3 : 3'h1;
      v[31:3] = {27'h0, i != 1, 1'b0};
      apb(1'b1, 12'h008, v);
      rd(12'h008, v, 32'hFFFFFFFF);
      check({27'h0, bus_width_select_out, 1'b0, memory_type_out},
        v, "md");
    end
    apb(1'b1, 12'h010, 32'h00000000);
    check({30'h0, early_read_disable_out, optimisation_disable_out},
      0, "hs");
    apb(1'b1, 12'h010, 32'hFFFFFFFF);
    rd(12'h010, 32'h00000006, 32'hFFFFFFFF);
    check({30'h0, early_read_disable_out, optimisation_disable_out},
      3, "hs");
    // protected writes are dropped without an error
    apb(1'b1, 12'h014, 32'h00000001);
    apb(1'b1, 12'h008, 32'h00000006);
    apb(1'b1, 12'h010, 32'h00000000);
    rd(12'h008, 32'h00000011, 32'hFFFFFFFF);
    rd(12'h010, 32'h00000006, 32'hFFFFFFFF);
    apb(1'b1, 12'h014, 32'h00000000);
    rd(12'h018, 32'h00000000, 32'hFFFFFFFF);
    for (i = 0; i < 5; i = i + 1) begin
      v = $random(seed);
      apb(1'b1, 12'h020 + 4 * i, v);
      rd(12'h020 + 4 * i, v, 32'hFFFFFFFF);
      check(line_element_count_out[32 * i +: 32], v, "delay");
    end
    target <= 9'h020;
    repeat (4) @(posedge clk_sys_in);
    rd(12'h00C, 32'h00000002, 32'h00000003);
    target <= 9'h1FF;
    repeat (600) @(posedge clk_sys_in);
    rd(12'h00C, 32'h0000FF04, 32'h0000FF04);
    check({24'h0, master_delay_value_out}, 32'hFF, "master_delay_value");
    check({31'h0, cke_out}, 1, "cke");
    init_done_in <= 1'b1;
    // self refresh after a partial-array change
    set_lp(32'h00010011);
    wait_cke(1'b0);
    check({31'h0, cke_out}, 0, "cke");
    check(ec, 1, "extwr");
    check({29'h0, lp_cfg_out[6:4]}, 1, "partial_array_refresh");
    access(3);
    wait_cke(1'b1);
    check({31'h0, cke_out}, 1, "cke");
    wait_cke(1'b0);
    check(ec, 1, "extwr");
    @(posedge clk_sys_in) bus_shared_in <= 1'b1;
    set_lp(32'h00010111);
    wait_cke(1'b0);
    check(ec + lc, 1, "modewr");
    check({30'h0, lp_cfg_out[9:8]}, 1, "tcr");
    @(posedge clk_sys_in) bus_shared_in <= 1'b0;
    l0 = lc;
    set_lp(32'h00000111);
    wait_cke(1'b0);
    check(lc, l0 + 1, "loadwr");
    // power-down with frozen clock, timeout restarted by an access
    for (e0 = 1; e0 < 3; e0 = e0 + 1) begin
      set_lp(32'h00000006 | (e0 << 12));
      repeat (20) @(posedge clk_sys_in);
      access(2);
      repeat (64 * e0 - 2) @(posedge clk_sys_in);
      check({31'h0, cke_out}, 1, "cke");
      wait_cke(1'b0);
      check({31'h0, cke_out}, 0, "cke");
      access(2);
      wait_cke(1'b1);
      check({31'h0, cke_out}, 1, "cke");
    end
    set_lp(32'h00010003);
    wait_cke(1'b0);
    check({30'h0, lp_cmd_out}, 3, "lpcmd");
    apb(1'b1, 12'h004, 32'h00010000);
    wait_cke(1'b1);
    check({31'h0, cke_out}, 1, "cke");
    apb(1'b1, 12'h008, 32'h00000010);
    set_lp(32'h00010003);
    repeat (200) @(posedge clk_sys_in);
    check({31'h0, cke_out}, 1, "cke");
    check(bad, 0, "modecke");
    end_sim;
  end
endmodule
